/* File: include/ecp_regs_map.svh */
// register offsets, field positions, reset values and timing counts of the parallel port block
`ifndef ECP_REGS_MAP_SVH
`define ECP_REGS_MAP_SVH
`define OFS_PIN_DATA 11'h000
`define OFS_STATUS 11'h001
`define OFS_CONTROL 11'h002
`define OFS_FIFO 11'h400
`define OFS_MODE_CTL 11'h402
`define OFS_INDEX 11'h403
`define OFS_IDATA 11'h404
`define IDX_CTL_ZERO 3'h0
`define IDX_CTL_TWO 3'h2
`define IDX_CTL_FOUR 3'h4
`define IDX_PORT_CFG 3'h5
`define CFG_GATE_BIT 4
`define CTL_RESET 6'h00
`define MODE_RESET 8'h15
`define CFGA_LOW 3'h4
`define CFGA_HIGH 4'h1
`define TIMEOUT_NS 10000
`define CLK_NS 40
`define TIMEOUT_CYC ((`TIMEOUT_NS + `CLK_NS - 1) / `CLK_NS)
`endif

/* File: include/ecp_pkg.sv */
// types shared by the parallel port block
package ecp_pkg;
  typedef enum logic [2:0] {
    mode_std = 3'b000, mode_bidir = 3'b001, mode_compat = 3'b010, mode_ext = 3'b011,
    mode_epp = 3'b100, mode_test = 3'b110, mode_cfg = 3'b111
  } mode_t;
  typedef struct packed {
    logic cmd;
    logic [7:0] data;
  } fifo_word_t;
  typedef struct packed {
    logic busy;
    logic ack_n;
    logic paper_out_in;
    logic selected_in;
    logic fault_n;
  } link_status_t;
  typedef enum logic [1:0] {rev_idle = 2'b00, rev_wait = 2'b01, rev_take = 2'b11} rev_state_t;
endpackage

/* File: logic/ecp_fifo.sv */
// synchronous fifo with valid and ready on both sides
module ecp_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, rp_r;
  logic [AW:0] cnt_r;
  logic push, pop;
  // refused accesses leave pointers and flags untouched
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];
  // storage
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end
  // pointers and fill count
  always_ff @(posedge mclk) begin
    if (!rst_n || flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

/* File: logic/ecp_port.sv */
// register, fifo and pin logic of an extended-capabilities parallel port
// What this block does
// - index and data registers reach four indirect registers, port config at five
// - indirect registers reachable only when config gate set and base bit set
// - pin data reads in modes 000/001 return live data line levels
// - mode 011 forward: command port write pushes byte tagged command
// - status bit 0 is timeout only in epp mode, else 1; writes ignored
// - timeout clears on epp entry, sets on 10 us timeout, clears on read
// - status bits 2,1 read 1; bits 3..6 mirror fault, select, paper, ack
// - status bit 7 is inverse of busy
// - control reads return stored contents, not pin levels
// - control bit 0 drives strobe inverted; hardware may strobe in 010/011
// - control bit 1 drives auto feed inverted; hardware adds handshake in 011
// - control bit 2 drives init non-inverted
// - control bit 4 gates ack interrupt, pin never floated
// - control bit 5 is direction, forced forward in modes 000 and 010
// - control bits 7,6 always read 1
// - mode 010: fifo port write pushes data; reads undefined, no effect
// - mode 011 backward: hardware fills fifo, host reads pop
// - mode 011 forward: fifo port write pushes data; reads no effect
// - mode 110: test fifo push and pop without link cycles
// - test mode overflow and underflow ignored; pops always from head
// - mode 111 config readback: 100 low, 0001 high, bit 3 port config bit 7
// - all fifo locations share one fifo chosen by offset and mode
// - mode control bits 7..5 select the operating mode
// - full writes and empty reads ignored, flags unchanged
`include "ecp_regs_map.svh"
module ecp_port #(
  parameter int FIFO_DEPTH = 16,
  parameter int TIMEOUT_CYCLES = `TIMEOUT_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [10:0] addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  input wire logic cfg_gate_en,
  input wire logic base_bit_hit,
  input wire logic epp_cycle_busy,
  input wire ecp_pkg::link_status_t link_in,
  input wire logic [7:0] link_data_lines_i,
  output logic [7:0] link_data_lines_o,
  output logic link_data_lines_oe,
  output logic strobe_out_n,
  output logic auto_feed_out_n,
  output logic init_out_n,
  output logic select_in_out_n,
  output logic ack_irq_en,
  output logic fifo_cmd_out,
  output logic fifo_empty,
  output logic fifo_full
);
  import ecp_pkg::*;

  // ----------------------------------------
  // registers and decode
  // ----------------------------------------
  logic [5:0] ctl_r;
  logic [7:0] mode_ctl_r;
  logic [2:0] index_r;
  logic [7:0] ind_r [4];
  logic [7:0] pin_latch_r;
  logic timeout_r;
  logic hw_strobe_r, hw_feed_r;
  localparam int CNT_W = $clog2(TIMEOUT_CYCLES + 1);
  logic [CNT_W-1:0] to_cnt_r;
  rev_state_t rev_r;
  mode_t mode;
  logic dir, fifo_hit, ind_ok, ind_valid;
  logic [1:0] ind_sel;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  fifo_word_t f_in, f_out;
  logic push_cmd, push_data, host_pop, rev_push;
  logic [7:0] rd_nxt;

  assign mode = mode_t'(mode_ctl_r[7:5]);
  assign dir = (mode == mode_std || mode == mode_compat) ? 1'b0 : ctl_r[5];
  assign fifo_hit = addr == `OFS_FIFO;
  assign ind_ok = cfg_gate_en && base_bit_hit;
  // four indirect slots; odd gaps ignored
  always_comb begin
    ind_valid = 1'b1;
    ind_sel = 2'd0;
    unique case (index_r)
      `IDX_CTL_ZERO: ind_sel = 2'd0;
      `IDX_CTL_TWO: ind_sel = 2'd1;
      `IDX_CTL_FOUR: ind_sel = 2'd2;
      `IDX_PORT_CFG: ind_sel = 2'd3;
      default: ind_valid = 1'b0;
    endcase
  end

  // control and pin data latch; status writes fall through, ignored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ctl_r <= `CTL_RESET;
      pin_latch_r <= 8'h00;
    end else if (wr_en) begin
      if (addr == `OFS_CONTROL) begin
        ctl_r <= wdata[5:0];
      end
      if (addr == `OFS_PIN_DATA && (mode == mode_std || mode == mode_bidir)) begin
        pin_latch_r <= wdata;
      end
    end
  end

  // mode register, also holds the index
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mode_ctl_r <= `MODE_RESET;
      index_r <= 3'h0;
    end else if (wr_en) begin
      if (addr == `OFS_MODE_CTL) begin
        mode_ctl_r <= {wdata[7:2], mode_ctl_r[1:0]};
      end
      if (addr == `OFS_INDEX && ind_ok) begin
        index_r <= wdata[2:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ind
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          ind_r[gi] <= 8'h00;
        end else if (wr_en && addr == `OFS_IDATA && ind_ok && ind_valid && ind_sel == 2'(gi)) begin
          ind_r[gi] <= wdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // fifo access
  // ----------------------------------------
  // command push
  assign push_cmd = wr_en && addr == `OFS_PIN_DATA && mode == mode_ext && !dir;
  assign push_data = wr_en && fifo_hit &&
    (mode == mode_compat || (mode == mode_ext && !dir) || mode == mode_test);
  assign host_pop = rd_en && fifo_hit && ((mode == mode_ext && dir) || mode == mode_test);
  assign rev_push = rev_r == rev_take;
  always_comb begin
    f_in.cmd = push_cmd;
    f_in.data = rev_push ? link_data_lines_i : wdata;
  end
  assign f_in_valid = push_cmd || push_data || rev_push;
  // forward drain: link handshake pops one word per strobe pulse
  assign f_out_ready = host_pop || (hw_strobe_r && (mode == mode_compat || mode == mode_ext));

  ecp_fifo #(.WIDTH($bits(fifo_word_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .flush(!(mode == mode_compat || mode == mode_ext || mode == mode_test)),
    .in_valid(f_in_valid),
    .in_ready(f_in_ready),
    .in_data(f_in),
    .out_valid(f_out_valid),
    .out_ready(f_out_ready),
    .out_data(f_out)
  );

  // ----------------------------------------
  // link handshake
  // ----------------------------------------
  // forward strobe pulse while data waits, not in test mode
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hw_strobe_r <= 1'b0;
    end else begin
      hw_strobe_r <= !hw_strobe_r && f_out_valid && !dir && !link_in.busy &&
        (mode == mode_compat || mode == mode_ext);
    end
  end

  // reverse fill: ask, wait for ack low, take a byte
  always_ff @(posedge mclk) begin
    if (!rst_n || !(mode == mode_ext && dir)) begin
      rev_r <= rev_idle;
      hw_feed_r <= 1'b0;
    end else begin
      unique case (rev_r)
        rev_idle: if (f_in_ready && !host_pop) begin
          rev_r <= rev_wait;
          hw_feed_r <= 1'b1;
        end
        rev_wait: if (!link_in.ack_n) begin
          rev_r <= rev_take;
          hw_feed_r <= 1'b0;
        end
        rev_take: rev_r <= rev_idle;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n || mode != mode_epp) begin
      to_cnt_r <= '0;
    end else if (epp_cycle_busy) begin
      to_cnt_r <= (to_cnt_r == CNT_W'(TIMEOUT_CYCLES)) ? to_cnt_r : to_cnt_r + 1'b1;
    end else begin
      to_cnt_r <= '0;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n || mode != mode_epp) begin
      timeout_r <= 1'b0;
    end else if (to_cnt_r == CNT_W'(TIMEOUT_CYCLES - 1) && epp_cycle_busy) begin
      timeout_r <= 1'b1;
    end else if (rd_en && addr == `OFS_STATUS) begin
      timeout_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    rd_nxt = 8'h00;
    unique case (addr)
      `OFS_PIN_DATA: rd_nxt = link_data_lines_i;
      `OFS_STATUS: rd_nxt = {!link_in.busy, link_in.ack_n, link_in.paper_out_in, link_in.selected_in,
        link_in.fault_n, 2'b11, (mode == mode_epp) ? timeout_r : 1'b1};
      `OFS_CONTROL: rd_nxt = {2'b11, ctl_r};
      `OFS_FIFO: rd_nxt = (mode == mode_cfg) ? {`CFGA_HIGH, ind_r[3][7], `CFGA_LOW} : f_out.data;
      `OFS_MODE_CTL: rd_nxt = {mode_ctl_r[7:2], !f_in_ready, !f_out_valid};
      `OFS_INDEX: rd_nxt = {5'h00, index_r};
      `OFS_IDATA: rd_nxt = (ind_ok && ind_valid) ? ind_r[ind_sel] : 8'h00;
      default: rd_nxt = 8'h00;
    endcase
  end

  // registered outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      strobe_out_n <= 1'b1;
      auto_feed_out_n <= 1'b1;
      init_out_n <= 1'b0;
      select_in_out_n <= 1'b1;
      ack_irq_en <= 1'b0;
      link_data_lines_o <= 8'h00;
      link_data_lines_oe <= 1'b0;
      fifo_cmd_out <= 1'b0;
      fifo_empty <= 1'b1;
      fifo_full <= 1'b0;
    end else begin
      rdata <= rd_en ? rd_nxt : 8'h00;
      strobe_out_n <= !(ctl_r[0] || hw_strobe_r);
      auto_feed_out_n <= !(ctl_r[1] || (mode == mode_ext && hw_feed_r));
      init_out_n <= ctl_r[2];
      select_in_out_n <= !ctl_r[3];
      ack_irq_en <= ctl_r[4];
      link_data_lines_o <= (mode == mode_std || mode == mode_bidir) ? pin_latch_r : f_out.data;
      link_data_lines_oe <= !dir;
      fifo_cmd_out <= f_out.cmd && f_out_valid;
      fifo_empty <= !f_out_valid;
      fifo_full <= !f_in_ready;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  // fixed status ones
  property p_status_fixed;
    @(posedge mclk) disable iff (!rst_n) rd_en && addr == `OFS_STATUS |=> rdata[2:1] == 2'b11;
  endproperty
  a_status_fixed: assert property (p_status_fixed) else $error("status bits 2,1 not 1");
  property p_busy_inv;
    @(posedge mclk) disable iff (!rst_n) rd_en && addr == `OFS_STATUS |=> rdata[7] == !$past(link_in.busy);
  endproperty
  a_busy_inv: assert property (p_busy_inv) else $error("status bit 7 not inverse busy");
  property p_ctl_ones;
    @(posedge mclk) disable iff (!rst_n) rd_en && addr == `OFS_CONTROL |=> rdata[7:6] == 2'b11;
  endproperty
  a_ctl_ones: assert property (p_ctl_ones) else $error("control bits 7,6 not 1");
  property p_non_epp_one;
    @(posedge mclk) disable iff (!rst_n) rd_en && addr == `OFS_STATUS && mode != mode_epp |=> rdata[0];
  endproperty
  a_non_epp_one: assert property (p_non_epp_one) else $error("timeout bit not 1 outside epp");
  property p_init_follow;
    @(posedge mclk) disable iff (!rst_n) ##1 init_out_n == $past(ctl_r[2]);
  endproperty
  a_init_follow: assert property (p_init_follow) else $error("init does not follow bit 2");
  property p_dir_forced;
    @(posedge mclk) disable iff (!rst_n) mode == mode_std ##1 mode == mode_std |-> link_data_lines_oe;
  endproperty
  a_dir_forced: assert property (p_dir_forced) else $error("direction not forced forward");
  property p_cfga;
    @(posedge mclk) disable iff (!rst_n) rd_en && fifo_hit && mode == mode_cfg |=>
      rdata[7:4] == 4'h1 && rdata[2:0] == 3'h4;
  endproperty
  a_cfga: assert property (p_cfga) else $error("config readback wrong");
  // full stays full; uses the live count, the registered flag lags a pop by a cycle
  property p_full_hold;
    @(posedge mclk) disable iff (!rst_n) !f_in_ready && !f_out_ready && !u_fifo.flush |=>
      !f_in_ready && fifo_full;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("full write changed fifo");
  property p_back_no_push;
    @(posedge mclk) disable iff (!rst_n) wr_en && addr == `OFS_PIN_DATA && mode == mode_ext && dir |->
      (!f_in_valid || rev_push);
  endproperty
  a_back_no_push: assert property (p_back_no_push) else $error("backward command write pushed");
  c_cmd_push: cover property (@(posedge mclk) push_cmd);
  c_rev_fill: cover property (@(posedge mclk) rev_push);
  c_test_pop: cover property (@(posedge mclk) host_pop && mode == mode_test);
  c_timeout: cover property (@(posedge mclk) $rose(timeout_r));
endmodule

/* File: tb/ecp_periph_model.sv */
// peripheral model: status lines, strobe capture, busy answer and reverse byte supply
module ecp_periph_model (
  input wire logic mclk,
  input wire logic strobe_out_n,
  input wire logic auto_feed_out_n,
  input wire logic drive_en,
  input wire logic [7:0] wire_data,
  input wire logic [4:0] status_set,
  input wire logic [7:0] rev_byte,
  output ecp_pkg::link_status_t link_in,
  output logic [7:0] periph_data,
  output logic [7:0] strobed_byte
);
  import ecp_pkg::*;
  logic busy_r;
  logic ack_low_r;
  logic strobe_d_r;

  // --------------------------------------------------
  // handshake answers
  // --------------------------------------------------
  // busy follows strobe one cycle late, so the port sees a real busy pulse
  always_ff @(posedge mclk) begin
    busy_r <= !strobe_out_n;
    strobe_d_r <= strobe_out_n;
    if (strobe_d_r && !strobe_out_n) begin
      strobed_byte <= wire_data;
    end
  end
  always_ff @(posedge mclk) ack_low_r <= !auto_feed_out_n && !drive_en;

  // status lines and data presented while the port has released the bus
  always_comb begin
    link_in = status_set;
    link_in.busy = status_set[4] | busy_r;
    if (ack_low_r) begin
      link_in.ack_n = 1'b0;
    end
    periph_data = rev_byte;
  end
endmodule

/* File: tb/testbench.sv */
// self-checking bench of the parallel port register and fifo block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import ecp_pkg::*;
  logic mclk, rst_n, wr_en, rd_en, cfg_gate_en, base_bit_hit, epp_cycle_busy;
  logic [10:0] addr;
  logic [7:0] wdata, rdata, dout, wire_data, periph_data, strobed_byte, rev_byte, d;
  logic oe, strobe_out_n, auto_feed_out_n, init_out_n, select_in_out_n, ack_irq_en;
  logic fifo_cmd_out, fifo_empty, fifo_full, rd_d;
  logic [4:0] stat;
  logic [8:0] e;
  logic [31:0] rnd;
  link_status_t link_in;
  logic [8:0] exp_q[$];
  int error_cnt, total_checks;

  // the wire level: port drives when enabled, else the peripheral does
  assign wire_data = oe ? dout : periph_data;

  ecp_port #(.FIFO_DEPTH(16), .TIMEOUT_CYCLES(8)) dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata), .cfg_gate_en(cfg_gate_en),
    .base_bit_hit(base_bit_hit), .epp_cycle_busy(epp_cycle_busy), .link_in(link_in),
    .link_data_lines_i(wire_data), .link_data_lines_o(dout), .link_data_lines_oe(oe),
    .strobe_out_n(strobe_out_n), .auto_feed_out_n(auto_feed_out_n), .init_out_n(init_out_n),
    .select_in_out_n(select_in_out_n), .ack_irq_en(ack_irq_en), .fifo_cmd_out(fifo_cmd_out),
    .fifo_empty(fifo_empty), .fifo_full(fifo_full));

  ecp_periph_model periph_u (.mclk(mclk), .strobe_out_n(strobe_out_n),
    .auto_feed_out_n(auto_feed_out_n), .drive_en(oe), .wire_data(wire_data), .status_set(stat),
    .rev_byte(rev_byte), .link_in(link_in), .periph_data(periph_data), .strobed_byte(strobed_byte));

  // --------------------------------------------------
  // helpers
  // --------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] st(input logic b0);
    return {~stat[4], stat[3:0], 2'b11, b0};
  endfunction

  task automatic chk(input string n, input logic [7:0] x, input logic [7:0] g);
    total_checks++;
    if (x !== g) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", n, x, g);
    end
  endtask

  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    @(negedge mclk);
    addr = a;
    wdata = v;
    wr_en = 1'b1;
    @(negedge mclk);
    wr_en = 1'b0;
  endtask

  // the expectation is queued first; c low marks an undefined read
  task automatic rd(input logic [10:0] a, input logic [7:0] x, input logic c);
    @(negedge mclk);
    exp_q.push_back({c, x});
    addr = a;
    rd_en = 1'b1;
    @(negedge mclk);
    rd_en = 1'b0;
  endtask

  // the flags lag a push or pop by a cycle, so let them settle before polling
  task automatic wait_empty(input logic want);
    int n;
    n = 0;
    repeat (2) @(negedge mclk);
    while (fifo_empty !== want && n < 300) begin
      @(negedge mclk);
      n++;
    end
    chk("fifo_empty", {7'h0, want}, {7'h0, fifo_empty});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // --------------------------------------------------
  // clock, read monitor, watchdog
  // --------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // rdata is registered, so it is judged one cycle after the read strobe
  always @(posedge mclk) rd_d <= rd_en;
  always @(negedge mclk) begin
    if (rd_d) begin
      e = exp_q.pop_front();
      if (e[8]) begin
        chk("rdata", e[7:0], rdata);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    conclude();
  end

  // --------------------------------------------------
  // main sequence
  // --------------------------------------------------
  initial begin
    {rst_n, wr_en, rd_en, cfg_gate_en, base_bit_hit, epp_cycle_busy} = 6'h00;
    addr = 11'h000;
    wdata = 8'h00;
    rev_byte = 8'h00;
    stat = 5'h09;
    rnd = 32'd95728;
    repeat (4) @(negedge mclk);
    rst_n = 1'b1;
    // status mirrors lines; bit 0 constant outside epp
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      stat = rnd[4:0];
      rd(11'h001, st(1'b1), 1'b1);
    end
    stat = 5'h09;
    // control readback and pin polarity
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      d = rnd[7:0] & 8'hdf;
      wr(11'h002, d);
      rd(11'h002, {2'b11, d[5:0]}, 1'b1);
      chk("pins", {3'h0, d[4], ~d[3], d[2], ~d[1], ~d[0]}, {3'h0, ack_irq_en, select_in_out_n,
        init_out_n, auto_feed_out_n, strobe_out_n});
    end
    wr(11'h002, 8'h0c);
    // pin data reads give live line levels; direction and its forcing
    wr(11'h000, 8'ha5);
    rd(11'h000, 8'ha5, 1'b1);
    wr(11'h402, 8'h35);
    wr(11'h002, 8'h24);
    // the enable is registered one edge behind the control bit
    @(negedge mclk);
    chk("oe", 8'h00, {7'h0, oe});
    rnd = lfsr(rnd);
    rev_byte = rnd[7:0];
    rd(11'h000, rev_byte, 1'b1);
    wr(11'h402, 8'h15);
    @(negedge mclk);
    chk("oe", 8'h01, {7'h0, oe});
    wr(11'h002, 8'h0c);
    // test fifo: fill past full, drain past empty, order kept
    wr(11'h402, 8'hd5);
    for (int i = 0; i < 17; i++) wr(11'h400, 8'h40 + 8'(i));
    chk("full", 8'h01, {7'h0, fifo_full});
    for (int i = 0; i < 17; i++) rd(11'h400, 8'h40 + 8'(i), i < 16);
    chk("empty", 8'h01, {7'h0, fifo_empty});
    // configuration readback and indirect registers behind the gate
    wr(11'h402, 8'hf5);
    cfg_gate_en = 1'b1;
    base_bit_hit = 1'b1;
    wr(11'h403, 8'h05);
    wr(11'h404, 8'h80);
    rd(11'h404, 8'h80, 1'b1);
    rd(11'h400, 8'h1c, 1'b1);
    wr(11'h404, 8'h00);
    rd(11'h400, 8'h14, 1'b1);
    wr(11'h403, 8'h02);
    wr(11'h404, 8'h5a);
    base_bit_hit = 1'b0;
    wr(11'h404, 8'h11);
    rd(11'h404, 8'h00, 1'b1);
    base_bit_hit = 1'b1;
    rd(11'h404, 8'h5a, 1'b1);
    // epp timeout flag: clear on entry, set by a long cycle, clear on read
    wr(11'h402, 8'h95);
    rd(11'h001, st(1'b0), 1'b1);
    epp_cycle_busy = 1'b1;
    repeat (12) @(negedge mclk);
    epp_cycle_busy = 1'b0;
    rd(11'h001, st(1'b1), 1'b1);
    rd(11'h001, st(1'b0), 1'b1);
    // set the flag again, leave and re-enter epp: entry must clear it
    epp_cycle_busy = 1'b1;
    repeat (12) @(negedge mclk);
    epp_cycle_busy = 1'b0;
    wr(11'h402, 8'h15);
    wr(11'h402, 8'h95);
    rd(11'h001, st(1'b0), 1'b1);
    // compatibility fifo and command fifo bytes reach the link
    wr(11'h402, 8'h15);
    wr(11'h402, 8'h55);
    wr(11'h400, 8'h3c);
    @(negedge mclk);
    chk("cmd_tag", 8'h00, {7'h0, fifo_cmd_out});
    wait_empty(1'b1);
    chk("strobed", 8'h3c, strobed_byte);
    wr(11'h402, 8'h75);
    wr(11'h000, 8'hc3);
    @(negedge mclk);
    chk("cmd_tag", 8'h01, {7'h0, fifo_cmd_out});
    wait_empty(1'b1);
    chk("strobed", 8'hc3, strobed_byte);
    wr(11'h400, 8'h5e);
    @(negedge mclk);
    chk("cmd_tag", 8'h00, {7'h0, fifo_cmd_out});
    wait_empty(1'b1);
    chk("strobed", 8'h5e, strobed_byte);
    // reverse fill: the port pulls bytes in by itself, host reads pop them
    wr(11'h402, 8'h35);
    wr(11'h002, 8'h2c);
    rev_byte = 8'h69;
    wr(11'h402, 8'h75);
    wait_empty(1'b0);
    wr(11'h000, 8'h77);
    rd(11'h400, 8'h69, 1'b1);
    wr(11'h402, 8'h35);
    repeat (3) @(negedge mclk);
    conclude();
  end
endmodule
